/* hw/cxt_control.sv */
// Mode selection, wake filter and dominant time-out of the CAN transceiver
`timescale 1ns/1ps
module cxt_control
  import cxt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Controller side
  input wire logic txData,
  input wire logic txValid,
  output logic txReady,
  input wire logic standbySel,
  output logic rxData,
  // Bus side, digital view of the driver and receivers
  output logic busDominant,
  output logic driverEn,
  input wire logic busIsDominant,
  // Status
  output logic timeoutActive
);
  ////////////////////////////////////////////////////////////////////////////
  // Transmit stream through the FIFO
  logic fifoValid;
  logic fifoData;
  logic txBit;
  logic txBitPrev_r;
  logic txFall;
  logic txRise;
  logic [TMR_W-1:0] domCnt_r;
  logic timedOut_r;
  cxt_mode_t mode_r;
  logic [TMR_W-1:0] wakeCnt_r;
  logic wake_r;
  logic rxData_r;
  logic busDom_r;

  // The FIFO pops one bit per clock; an empty FIFO reads as recessive
  cxt_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) uFifo (
    .clk(clk),
    .rst(rst),
    .inValid(txValid),
    .inReady(txReady),
    .inData(txData),
    .outValid(fifoValid),
    .outReady(1'b1),
    .outData(fifoData)
  );

  // Missing data behaves like the pulled-up open input
  assign txBit = fifoValid ? fifoData : 1'b1; // see [RL14]
  assign txFall = txBitPrev_r && !txBit;
  assign txRise = !txBitPrev_r && txBit;

  // Edge history, reset high like an idle recessive pin
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      txBitPrev_r <= 1'b1;
    end
    else
    begin
      txBitPrev_r <= txBit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode follows the select pin directly
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mode_r <= CXT_STANDBY;
    end
    else
    begin
      // Bus activity never changes the mode
      mode_r <= standbySel ? CXT_STANDBY : CXT_NORMAL; // see [RL1] see [RL2] see [RL6]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dominant time-out timer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      domCnt_r <= '0;
      timedOut_r <= 1'b0;
    end
    else
    begin
      if (txRise)
      begin
        // Release within one cycle, well inside the release time
        domCnt_r <= '0; // see [RL11]
        timedOut_r <= 1'b0; // see [RL16]
      end
      else if (txFall)
      begin
        domCnt_r <= TMR_W'(1); // see [RL9]
      end
      else if (!txBit && !timedOut_r && domCnt_r != '0)
      begin
        if (domCnt_r == TMR_W'(DOM_TIMEOUT_CYC - 1)) // see [RL12]
        begin
          timedOut_r <= 1'b1; // see [RL10] see [RL18]
        end
        else
        begin
          domCnt_r <= domCnt_r + 1'b1;
        end
      end
    end
  end

  // Driver output: dominant only in normal mode, low input, no time-out
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busDom_r <= 1'b0;
    end
    else
    begin
      busDom_r <= (mode_r == CXT_NORMAL) && !txBit && !timedOut_r; // see [RL3] see [RL4] see [RL8]
    end
  end

  assign busDominant = busDom_r;
  assign driverEn = (mode_r == CXT_NORMAL) && !timedOut_r;
  assign timeoutActive = timedOut_r;

  ////////////////////////////////////////////////////////////////////////////
  // Standby wake filter: dominant must outlast the filter time
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wakeCnt_r <= '0;
      wake_r <= 1'b0;
    end
    else
    begin
      if (mode_r != CXT_STANDBY || !busIsDominant)
      begin
        wakeCnt_r <= '0;
        wake_r <= 1'b0;
      end
      else if (wakeCnt_r == TMR_W'(WAKE_FILTER_CYC))
      begin
        wake_r <= 1'b1; // see [RL5] see [RL18]
      end
      else
      begin
        wakeCnt_r <= wakeCnt_r + 1'b1;
      end
    end
  end

  // Receive output: bus level in normal mode, filtered wake in standby
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rxData_r <= RXD_RESET;
    end
    else if (mode_r == CXT_NORMAL)
    begin
      rxData_r <= !busIsDominant; // see [RL17] see [RL3]
    end
    else
    begin
      rxData_r <= !wake_r; // see [RL5]
    end
  end

  assign rxData = rxData_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  localparam int WF = WAKE_FILTER_CYC;
  localparam int RC = RELEASE_CYC;
  logic [TMR_W-1:0] domRun_r;
  logic [TMR_W-1:0] lowRun_r;

  // Checker-only dominant run in standby, kept apart from the filter it judges
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      domRun_r <= '0;
    end
    else if (mode_r == CXT_STANDBY && busIsDominant)
    begin
      // Saturate just past the filter length so a long wake cannot wrap
      if (domRun_r != TMR_W'(WF + 1))
      begin
        domRun_r <= domRun_r + 1'b1;
      end
    end
    else
    begin
      domRun_r <= '0;
    end
  end

  // Checker-only run of low transmit bits, independent of the time-out timer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lowRun_r <= '0;
    end
    else if (!txBit)
    begin
      if (lowRun_r != '1)
      begin
        lowRun_r <= lowRun_r + 1'b1;
      end
    end
    else
    begin
      lowRun_r <= '0;
    end
  end

  sequence seqDomHeld;
    !txBit && !txRise;
  endsequence

  AST_STANDBY_NO_DRIVE: assert property (@(posedge clk) disable iff (rst) // see [RL4]
    (mode_r == CXT_STANDBY) |-> ##1 !busDom_r)
    else $error("Bus driven in standby");

  AST_MODE_FOLLOWS_SELECT: assert property (@(posedge clk) disable iff (rst) // see [RL1]
    !standbySel |=> (mode_r == CXT_NORMAL))
    else $error("Normal mode not entered on low select");

  AST_STANDBY_ON_HIGH: assert property (@(posedge clk) disable iff (rst) // see [RL2]
    standbySel |=> (mode_r == CXT_STANDBY))
    else $error("Standby not entered on high select");

  AST_TX_DOMINANT: assert property (@(posedge clk) disable iff (rst) // see [RL8]
    (mode_r == CXT_NORMAL && !txBit && !timedOut_r) |=> busDom_r)
    else $error("Low transmit did not make bus dominant");

  AST_RX_NORMAL: assert property (@(posedge clk) disable iff (rst) // see [RL17]
    (mode_r == CXT_NORMAL) |=> (rxData_r == !$past(busIsDominant)))
    else $error("Receive output does not follow bus");

  AST_WAKE_FILTER: assert property (@(posedge clk) disable iff (rst) // see [RL5]
    $fell(rxData_r) && $past(mode_r) == CXT_STANDBY |-> $past(domRun_r) > TMR_W'(WF))
    else $error("Wake reported on short dominant");

  AST_TIMEOUT_MIN: assert property (@(posedge clk) disable iff (rst) // see [RL12]
    $rose(timedOut_r) |-> (lowRun_r >= TMR_W'(DOM_TIMEOUT_MIN_CYC)))
    else $error("Time-out shorter than minimum");

  AST_TIMEOUT_CLEAR: assert property (@(posedge clk) disable iff (rst) // see [RL11]
    txRise |=> (domCnt_r == '0 && !timedOut_r))
    else $error("Rising edge did not clear timer");

  AST_RELEASE: assert property (@(posedge clk) disable iff (rst) // see [RL16]
    (timedOut_r && txRise) |-> ##[1:RC] driverEn || mode_r == CXT_STANDBY)
    else $error("Driver not re-enabled after release");

  AST_TIMER_START: assert property (@(posedge clk) disable iff (rst) // see [RL9]
    txFall |=> (domCnt_r == TMR_W'(1)))
    else $error("Timer did not start on falling edge");

  AST_HELD_NO_TIMEOUT: assert property (@(posedge clk) disable iff (rst) // see [RL10]
    txRise ##1 seqDomHeld [*8] |-> !timedOut_r)
    else $error("Time-out fired too early");

  AST_WAKE_WF: assert property (@(posedge clk) disable iff (rst) // see [RL18]
    (mode_r == CXT_STANDBY && wakeCnt_r == TMR_W'(WF) && busIsDominant && standbySel)
      |=> wake_r)
    else $error("Wake flag not set at filter end");
endmodule

/* hw/cxt_pkg.sv */
// Constants for the CAN transceiver mode and time-out control
// Notes on behaviour
// [RL1] Standby-select low selects normal mode
// [RL2] Standby-select high selects standby mode
// [RL3] Normal mode drives bus and reports it
// [RL4] Standby turns driver off, receiver keeps watching
// [RL5] Standby wake only after dominant over 3 us
// [RL6] Standby held until standby-select goes low
// [RL7] Controller treats standby low receive as wake
// [RL8] Transmit low dominant, high recessive
// [RL9] Time-out timer starts on transmit falling edge
// [RL10] Expired time-out disables driver, bus recessive
// [RL11] Transmit rising edge clears the time-out timer
// [RL12] Time-out never shorter than 300 us
// [RL13] Controller bit rate at least 40 kbit/s
// [RL14] Transmit input weakly pulled high
// [RL15] Controller drives standby-select low for normal
// [RL16] Rising edge re-enables driver within 1 us
// [RL17] Normal receive low dominant, high recessive
// [RL18] Durations counted from internal timebase counters
package cxt_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int DOM_TIMEOUT_US = 2000;
  localparam int DOM_TIMEOUT_MIN_US = 300;
  localparam int WAKE_FILTER_US = 3;
  localparam int RELEASE_TIME_US = 1;
  // Cycles derived from the 20 MHz clock
  localparam int DOM_TIMEOUT_CYC = DOM_TIMEOUT_US * (CLK_HZ / 1000000);
  localparam int DOM_TIMEOUT_MIN_CYC = DOM_TIMEOUT_MIN_US * (CLK_HZ / 1000000);
  localparam int WAKE_FILTER_CYC = WAKE_FILTER_US * (CLK_HZ / 1000000);
  localparam int RELEASE_CYC = RELEASE_TIME_US * (CLK_HZ / 1000000);
  localparam int TMR_W = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_W = 1;
  localparam logic RXD_RESET = 1'b1;
  typedef enum logic {CXT_NORMAL, CXT_STANDBY} cxt_mode_t;
endpackage

/* hw/cxt_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module cxt_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Write side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Read side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic doWr;
  logic doRd;

  // Honest full and empty from the occupancy count
  assign inReady = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;
  assign outData = mem[rdPtr_r];

  // Storage array, no reset needed on data
  always_ff @(posedge clk)
  begin
    if (doWr)
    begin
      mem[wrPtr_r] <= inData;
    end
  end

  // Pointers and count
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (doWr)
      begin
        wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
      end
      if (doRd)
      begin
        rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(doWr) - (AW+1)'(doRd);
    end
  end
endmodule

/* verif/cxt_bus_model.sv */
// Digital model of the CAN bus wired-AND as seen by the receiver
`timescale 1ns/1ps
module cxt_bus_model
(
  // Local driver
  input wire logic busDominant,
  input wire logic driverEn,
  // Other nodes
  input wire logic otherDom,
  // Receiver view
  output logic busIsDominant
);
  // Any enabled dominant driver wins; idle bus is recessive
  assign busIsDominant = (busDominant & driverEn) | otherDom;
endmodule

/* verif/cxt_control_tb_top.sv */
// Self-checking testbench for the transceiver mode and time-out control
`timescale 1ns/1ps
module cxt_control_tb_top;
  import cxt_pkg::*;
  logic clk, rst, txData, txValid, txReady, standbySel, rxData, prevBus;
  logic busDominant, driverEn, busIsDominant, timeoutActive, otherDom;
  logic [31:0] rnd;
  logic [1:0] hist;
  int fails, compares, n;
  //////////////////////////////////////////////////////////////////
  cxt_control i_cxt_control (.clk(clk), .rst(rst), .txData(txData), .txValid(txValid),
    .txReady(txReady), .standbySel(standbySel), .rxData(rxData),
    .busDominant(busDominant), .driverEn(driverEn), .busIsDominant(busIsDominant),
    .timeoutActive(timeoutActive));
  cxt_bus_model i_cxt_bus_model (.busDominant(busDominant), .driverEn(driverEn),
    .otherDom(otherDom), .busIsDominant(busIsDominant));
  // Clock, 50 ns period
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////
  // Stimulus source, fixed seed keeps runs repeatable
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Driver output expected from a transmit bit
  function automatic logic expDom(input logic b);
    expDom = ~b;
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic summarize;
    if (fails == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Hold one transmit level for k cycles; the stream never stalls
  task automatic send(input logic b, input int k);
    txValid = 1'b1;
    txData = b;
    for (int i = 0; i < k; i++)
    begin
      cyc(1);
      chk(txReady === 1'b1, "fifo refused");
    end
  endtask
  //////////////////////////////////////////////////////////////////
  initial
  begin
    fails = 0;
    compares = 0;
    rnd = 32'h87A5;
    rst = 1'b1;
    txData = 1'b1;
    txValid = 1'b0;
    standbySel = 1'b0;
    otherDom = 1'b0;
    hist = 2'b11;
    cyc(16);
    chk(rxData === 1'b1 && busDominant === 1'b0 && driverEn === 1'b0, "reset values");
    rst = 1'b0;
    cyc(2);
    // Random traffic from us and other nodes in normal mode, with stalls
    for (int i = 0; i < 400; i++)
    begin
      rnd = lfsr(rnd);
      txValid = rnd[3] | rnd[4];
      txData = rnd[0];
      otherDom = rnd[1] & rnd[2];
      #1 prevBus = busIsDominant;
      cyc(1);
      // A stalled cycle leaves the stream empty, which reads as recessive
      hist = {hist[0], txValid ? txData : 1'b1};
      chk(driverEn === 1'b1, "driver off in normal");
      chk(busDominant === expDom(hist[1]), "bus level");
      chk(rxData === ~prevBus, "receive level");
    end
    otherDom = 1'b0;
    // Two long dominant runs split by a recessive bit never trip
    send(1'b0, DOM_TIMEOUT_CYC * 5 / 8);
    send(1'b1, 1);
    send(1'b0, DOM_TIMEOUT_CYC * 5 / 8);
    chk(timeoutActive === 1'b0 && busDominant === 1'b1, "timer not cleared");
    send(1'b1, 3);
    // Stuck dominant trips the time-out
    txData = 1'b0;
    n = 0;
    while (timeoutActive !== 1'b1 && n < DOM_TIMEOUT_CYC + 10)
    begin
      cyc(1);
      n++;
    end
    chk(n >= DOM_TIMEOUT_MIN_CYC, "time-out too short");
    chk(n <= DOM_TIMEOUT_CYC + 4, "time-out late");
    send(1'b0, 5);
    chk(driverEn === 1'b0 && busIsDominant === 1'b0, "bus not released");
    // Release rising edge re-enables the driver
    txData = 1'b1;
    n = 0;
    while (driverEn !== 1'b1 && n < RELEASE_CYC)
    begin
      cyc(1);
      n++;
    end
    chk(driverEn === 1'b1 && timeoutActive === 1'b0, "no release");
    // Standby: driver off, short activity filtered, long one wakes
    standbySel = 1'b1;
    send(1'b0, 10);
    chk(driverEn === 1'b0 && busDominant === 1'b0, "driving in standby");
    send(1'b1, 3);
    otherDom = 1'b1;
    cyc(WAKE_FILTER_CYC);
    chk(rxData === 1'b1, "short pulse woke");
    otherDom = 1'b0;
    cyc(3);
    otherDom = 1'b1;
    n = 0;
    while (rxData !== 1'b0 && n < 100)
    begin
      cyc(1);
      n++;
    end
    chk(n > WAKE_FILTER_CYC && n <= WAKE_FILTER_CYC + 4, "wake timing");
    otherDom = 1'b0;
    cyc(5);
    chk(driverEn === 1'b0 && rxData === 1'b1, "left standby");
    standbySel = 1'b0;
    cyc(3);
    chk(driverEn === 1'b1, "no normal mode");
    summarize;
  end
endmodule
